// ==== logic/pwmf_map.vh ====
// Behaviour
// - each generator holds fault select masks: four external inputs, eight comparator lines.
// - generator fault is OR of selected sources, external inputs polarity-adjusted first.
// - after reset only first external input faults; masks apply in extended mode only.
// - writing one to an interrupt status bit clears that pending interrupt.
// - six events recorded: zero, load, compare A up/down, compare B up/down.
// - raw and masked interrupt status both readable; masked is raw gated by enables.
// - enable register holds one interrupt enable per event; cleared bit masks it.
// - same register holds six trigger enables gating trigger outputs independently.
// - period is programmed tick count between successive zero event pulses.
// - period writes wait for the update point; later write replaces pending value.
// - period read returns last programmed value, even while update is pending.
// - each external fault input has selectable assertion polarity before combination.
// - in minimum hold mode an asserted fault stays asserted programmed cycle count.
// - latched mode holds fault status until software clears; otherwise live state.
`ifndef PWMF_MAP_VH
`define PWMF_MAP_VH
`define PWMF_GEN_SHIFT      6
`define PWMF_OFS_MODE       4'h0
`define PWMF_OFS_SRC_EXT    4'h1
`define PWMF_OFS_SRC_CMP    4'h2
`define PWMF_OFS_SENSE      4'h3
`define PWMF_OFS_MINHOLD    4'h4
`define PWMF_OFS_FSTAT_EXT  4'h5
`define PWMF_OFS_FSTAT_CMP  4'h6
`define PWMF_OFS_INTEN      4'h7
`define PWMF_OFS_RIS        4'h8
`define PWMF_OFS_MIS        4'h9
`define PWMF_OFS_PERIOD     4'ha
`define PWMF_OFS_ACTIVE     4'hb
`define PWMF_MODE_SRC_BIT   0
`define PWMF_MODE_HOLD_BIT  1
`define PWMF_MODE_LATCH_BIT 2
`define PWMF_INTEN_IRQ_LSB  0
`define PWMF_INTEN_TRIG_LSB 8
`define PWMF_ACTIVE_PEND_BIT 16
`define PWMF_RST_MODE       3'h0
`define PWMF_RST_SRC_EXT    4'h1
`define PWMF_RST_SRC_CMP    8'h00
`define PWMF_RST_SENSE      4'h0
`define PWMF_RST_MINHOLD    16'h0000
`define PWMF_RST_INTEN      14'h0000
`define PWMF_RST_PERIOD     16'h0000
`define PWMF_RESP_OKAY      2'b00
`define PWMF_RESP_SLVERR    2'b10
`endif

// ==== logic/pwmf_fault.v ====
`include "pwmf_map.vh"
module pwmf_fault (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  ext_fault_input_k,
	input  wire [7:0]  cmp_trig,
	input  wire [2:0]  mode,
	input  wire [3:0]  src_ext,
	input  wire [7:0]  src_cmp,
	input  wire [3:0]  sense_low,
	input  wire [15:0] min_hold,
	input  wire [3:0]  clr_ext,
	input  wire [7:0]  clr_cmp,
	output reg  [3:0]  stat_ext_reg,
	output reg  [7:0]  stat_cmp_reg,
	output reg         fault_reg
);
	wire [3:0]  adj_ext;
	wire        raw_fault;
	reg  [15:0] hold_reg;

	assign adj_ext   = ext_fault_input_k ^ sense_low;
	// extended mode ORs selected lines, otherwise first external input only
	assign raw_fault = mode[`PWMF_MODE_SRC_BIT] ?
		((|(adj_ext & src_ext)) | (|(cmp_trig & src_cmp))) : adj_ext[0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			hold_reg     <= 16'h0000;
			fault_reg    <= 1'b0;
			stat_ext_reg <= 4'h0;
			stat_cmp_reg <= 8'h00;
		end else begin
			if (raw_fault)
				hold_reg <= min_hold;
			else if (hold_reg != 16'h0000)
				hold_reg <= hold_reg - 16'h0001;
			fault_reg <= raw_fault | (mode[`PWMF_MODE_HOLD_BIT] && hold_reg > 16'h0001);
			if (mode[`PWMF_MODE_LATCH_BIT]) begin
				// new assertion wins over a clear in the same cycle
				stat_ext_reg <= (stat_ext_reg & ~clr_ext) | adj_ext;
				stat_cmp_reg <= (stat_cmp_reg & ~clr_cmp) | cmp_trig;
			end else begin
				stat_ext_reg <= adj_ext;
				stat_cmp_reg <= cmp_trig;
			end
		end
	end
endmodule

// ==== logic/pwmf_slice.v ====
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`include "pwmf_map.vh"
module pwmf_slice (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [3:0]  ext_fault_input_k,
	input  wire [7:0]  cmp_trig_line,
	input  wire [3:0]  cmp_a_up,
	input  wire [3:0]  cmp_a_down,
	input  wire [3:0]  cmp_b_up,
	input  wire [3:0]  cmp_b_down,
	output wire [3:0]  gen_fault,
	output reg  [3:0]  gen_zero,
	output reg  [23:0] gen_trig,
	output reg         irq
);
	reg  [3:0]  pin_s1_reg;
	reg  [3:0]  pin_s2_reg;
	reg  [3:0]  pin_s3_reg;
	reg  [3:0]  pin_filt_reg;
	reg  [2:0]  mode_reg      [0:3];
	reg  [3:0]  src_ext_reg   [0:3];
	reg  [7:0]  src_cmp_reg   [0:3];
	reg  [3:0]  sense_reg     [0:3];
	reg  [15:0] minhold_reg   [0:3];
	reg  [13:0] inten_reg     [0:3];
	reg  [5:0]  ris_reg       [0:3];
	reg  [15:0] per_prog_reg  [0:3];
	reg  [15:0] per_act_reg   [0:3];
	reg         per_pend_reg  [0:3];
	reg  [15:0] cnt_reg       [0:3];
	reg  [3:0]  clr_ext_reg   [0:3];
	reg  [7:0]  clr_cmp_reg   [0:3];
	wire [3:0]  stat_ext      [0:3];
	wire [7:0]  stat_cmp      [0:3];
	reg  [5:0]  evt           [0:3];
	reg         aw_full_reg;
	reg         w_full_reg;
	reg  [7:0]  awaddr_reg;
	reg  [31:0] wdata_reg;
	reg  [3:0]  wstrb_reg;
	reg  [31:0] rd_val;
	reg         rd_err;
	reg         any_mis;
	wire        wr_go;
	wire [31:0] wmask;
	wire [1:0]  wr_gen;
	wire [3:0]  wr_idx;
	wire [1:0]  rd_gen;
	wire [3:0]  rd_idx;
	integer     g;
	genvar      gv;

	// byte-lane merge of a write into an existing register value
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [31:0] mask;
		begin
			merge = (old & ~mask) | (data & mask);
		end
	endfunction

	// index of register slot within a generator window
	function [3:0] reg_idx;
		input [7:0] addr;
		begin
			reg_idx = addr[5:2];
		end
	endfunction

	function [1:0] gen_idx;
		input [7:0] addr;
		begin
			gen_idx = addr[7:`PWMF_GEN_SHIFT];
		end
	endfunction

	function mapped;
		input [3:0] idx;
		begin
			mapped = (idx <= `PWMF_OFS_ACTIVE);
		end
	endfunction

	assign wr_go  = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	assign wmask  = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign wr_gen = gen_idx(awaddr_reg);
	assign wr_idx = reg_idx(awaddr_reg);
	assign rd_gen = gen_idx(s_axi_araddr);
	assign rd_idx = reg_idx(s_axi_araddr);

	// fault pins: three stages, change accepted when last two agree
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_reg   <= 4'h0;
			pin_s2_reg   <= 4'h0;
			pin_s3_reg   <= 4'h0;
			pin_filt_reg <= 4'h0;
		end else begin
			pin_s1_reg <= ext_fault_input_k;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_filt_reg <= (pin_s2_reg & pin_s3_reg) | (pin_filt_reg & (pin_s2_reg ^ pin_s3_reg));
		end
	end

	generate
		for (gv = 0; gv < 4; gv = gv + 1) begin : gen_slot
			pwmf_fault u_fault (
				.aclk              (aclk),
				.aresetn           (aresetn),
				.ext_fault_input_k (pin_filt_reg),
				.cmp_trig          (cmp_trig_line),
				.mode              (mode_reg[gv]),
				.src_ext           (src_ext_reg[gv]),
				.src_cmp           (src_cmp_reg[gv]),
				.sense_low         (sense_reg[gv]),
				.min_hold          (minhold_reg[gv]),
				.clr_ext           (clr_ext_reg[gv]),
				.clr_cmp           (clr_cmp_reg[gv]),
				.stat_ext_reg      (stat_ext[gv]),
				.stat_cmp_reg      (stat_cmp[gv]),
				.fault_reg         (gen_fault[gv])
			);
		end
	endgenerate

	// counter events per generator
	always @* begin
		for (g = 0; g < 4; g = g + 1) begin
			evt[g][0] = (per_act_reg[g] != 16'h0000) && (cnt_reg[g] == 16'h0000);
			evt[g][1] = (per_act_reg[g] != 16'h0000) && (cnt_reg[g] == per_act_reg[g] - 16'h0001);
			evt[g][2] = cmp_a_up[g];
			evt[g][3] = cmp_a_down[g];
			evt[g][4] = cmp_b_up[g];
			evt[g][5] = cmp_b_down[g];
		end
	end

	// read mux
	always @* begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		case (rd_idx)
			`PWMF_OFS_MODE:      rd_val[2:0]  = mode_reg[rd_gen];
			`PWMF_OFS_SRC_EXT:   rd_val[3:0]  = src_ext_reg[rd_gen];
			`PWMF_OFS_SRC_CMP:   rd_val[7:0]  = src_cmp_reg[rd_gen];
			`PWMF_OFS_SENSE:     rd_val[3:0]  = sense_reg[rd_gen];
			`PWMF_OFS_MINHOLD:   rd_val[15:0] = minhold_reg[rd_gen];
			`PWMF_OFS_FSTAT_EXT: rd_val[3:0]  = stat_ext[rd_gen];
			`PWMF_OFS_FSTAT_CMP: rd_val[7:0]  = stat_cmp[rd_gen];
			`PWMF_OFS_INTEN:     rd_val[13:0] = inten_reg[rd_gen];
			`PWMF_OFS_RIS:       rd_val[5:0]  = ris_reg[rd_gen];
			`PWMF_OFS_MIS:       rd_val[5:0]  = ris_reg[rd_gen] & inten_reg[rd_gen][5:0];
			`PWMF_OFS_PERIOD:    rd_val[15:0] = per_prog_reg[rd_gen];
			`PWMF_OFS_ACTIVE:    rd_val[16:0] = {per_pend_reg[rd_gen], per_act_reg[rd_gen]};
			default:             rd_err = 1'b1;
		endcase
	end

	always @* begin
		any_mis = 1'b0;
		for (g = 0; g < 4; g = g + 1)
			any_mis = any_mis | (|(ris_reg[g] & inten_reg[g][5:0]));
	end

	// write and read channels
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PWMF_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PWMF_RESP_OKAY;
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			awaddr_reg    <= 8'h00;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg   <= 1'b1;
				awaddr_reg    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(wr_idx) ? `PWMF_RESP_OKAY : `PWMF_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_err ? `PWMF_RESP_SLVERR : `PWMF_RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// per-generator registers, period pipeline, events
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (g = 0; g < 4; g = g + 1) begin
				mode_reg[g]     <= `PWMF_RST_MODE;
				src_ext_reg[g]  <= `PWMF_RST_SRC_EXT;
				src_cmp_reg[g]  <= `PWMF_RST_SRC_CMP;
				sense_reg[g]    <= `PWMF_RST_SENSE;
				minhold_reg[g]  <= `PWMF_RST_MINHOLD;
				inten_reg[g]    <= `PWMF_RST_INTEN;
				ris_reg[g]      <= 6'h00;
				per_prog_reg[g] <= `PWMF_RST_PERIOD;
				per_act_reg[g]  <= `PWMF_RST_PERIOD;
				per_pend_reg[g] <= 1'b0;
				cnt_reg[g]      <= 16'h0000;
				clr_ext_reg[g]  <= 4'h0;
				clr_cmp_reg[g]  <= 8'h00;
			end
			gen_zero <= 4'h0;
			gen_trig <= 24'h00_0000;
			irq      <= 1'b0;
		end else begin
			irq <= any_mis;
			for (g = 0; g < 4; g = g + 1) begin
				clr_ext_reg[g] <= 4'h0;
				clr_cmp_reg[g] <= 8'h00;
				gen_zero[g] <= evt[g][0];
				gen_trig[g*6 +: 6] <= evt[g] & inten_reg[g][`PWMF_INTEN_TRIG_LSB +: 6];
				// counter runs period ticks from zero to zero
				if (per_act_reg[g] == 16'h0000 || cnt_reg[g] == 16'h0000)
					cnt_reg[g] <= (per_pend_reg[g] ? per_prog_reg[g] : per_act_reg[g]) - 16'h0001;
				else
					cnt_reg[g] <= cnt_reg[g] - 16'h0001;
				if (per_act_reg[g] == 16'h0000)
					cnt_reg[g] <= per_pend_reg[g] ? per_prog_reg[g] - 16'h0001 : 16'h0000;
				// update point: zero event, or idle generator
				if (per_pend_reg[g] && (evt[g][0] || per_act_reg[g] == 16'h0000)) begin
					per_act_reg[g]  <= per_prog_reg[g];
					per_pend_reg[g] <= 1'b0;
				end
				// sticky status, event beats a same-cycle clear
				ris_reg[g] <= ris_reg[g] | evt[g];
				if (wr_go && wr_gen == g) begin
					case (wr_idx)
						`PWMF_OFS_MODE:      mode_reg[g]    <= wdata_reg[2:0] & wmask[2:0]
							| mode_reg[g] & ~wmask[2:0];
						`PWMF_OFS_SRC_EXT:   src_ext_reg[g] <= wdata_reg[3:0] & wmask[3:0]
							| src_ext_reg[g] & ~wmask[3:0];
						`PWMF_OFS_SRC_CMP:   src_cmp_reg[g] <= wdata_reg[7:0] & wmask[7:0]
							| src_cmp_reg[g] & ~wmask[7:0];
						`PWMF_OFS_SENSE:     sense_reg[g]   <= wdata_reg[3:0] & wmask[3:0]
							| sense_reg[g] & ~wmask[3:0];
						`PWMF_OFS_MINHOLD:   minhold_reg[g] <= wdata_reg[15:0] & wmask[15:0]
							| minhold_reg[g] & ~wmask[15:0];
						`PWMF_OFS_FSTAT_EXT: clr_ext_reg[g] <= wdata_reg[3:0] & wmask[3:0];
						`PWMF_OFS_FSTAT_CMP: clr_cmp_reg[g] <= wdata_reg[7:0] & wmask[7:0];
						`PWMF_OFS_INTEN:     inten_reg[g]   <= wdata_reg[13:0] & wmask[13:0]
							| inten_reg[g] & ~wmask[13:0];
						`PWMF_OFS_RIS, `PWMF_OFS_MIS:
							ris_reg[g] <= (ris_reg[g] & ~(wdata_reg[5:0] & wmask[5:0])) | evt[g];
						`PWMF_OFS_PERIOD: begin
							per_prog_reg[g] <= wdata_reg[15:0] & wmask[15:0]
								| per_prog_reg[g] & ~wmask[15:0];
							per_pend_reg[g] <= 1'b1;
						end
						default: ;
					endcase
				end
			end
		end
	end
endmodule

// ==== bench/pwmf_properties.sv ====
module pwmf_props (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [3:0]  cmp_a_up,
	input logic [3:0]  cmp_a_down,
	input logic [23:0] gen_trig,
	input logic        irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_trig_a_up: assert property (gen_trig[2] |-> $past(cmp_a_up[0])) else $error("trigger without event");
	a_trig_a_down: assert property (gen_trig[3] |-> $past(cmp_a_down[0])) else $error("trigger without event");
	a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready stayed");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no write response");
	a_b_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stayed");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
	a_r_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stayed");
	a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && gen_trig == 24'h000000)
		else $error("outputs busy after reset");
	c_irq: cover property ($rose(irq));
	c_trig: cover property (gen_trig[3]);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind pwmf_slice pwmf_props u_props (.*);

// ==== bench/pwmf_src.sv ====
module pwmf_src (
	input  logic       aclk,
	input  logic [3:0] ext_req,
	input  logic [7:0] cmp_req,
	output logic [3:0] ext_fault_input_k,
	output logic [7:0] cmp_trig_line
);
	timeunit 1ns;
	timeprecision 100ps;
	// pins move off the clock grid
	always @(ext_req) ext_fault_input_k <= #1.3 ext_req;
	always @(posedge aclk) cmp_trig_line <= cmp_req;
endmodule

// ==== bench/tb_pwmf_slice.sv ====
module tb_pwmf_slice;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cmp_trig_line, cmp_req = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
	logic [3:0] s_axi_wstrb = 4'hf, ext_fault_input_k, gen_fault, gen_zero, ext_req = 4'he;
	logic [3:0] cmp_a_up = 4'h0, cmp_a_down = 4'h0, cmp_b_up = 4'h0, cmp_b_down = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [23:0] gen_trig;
	int fail_count = 0, comparisons = 0, gap;
	always #2 aclk = ~aclk;
	pwmf_slice uut (.*);
	pwmf_src partner (.*);
	task finish_test;
		$display("counts: %0d compares, %0d errors", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	task tmo(input bit bad);
		chk("handshake timeout", 32'h0, {31'h0, bad});
		if (bad)
			finish_test;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			n++;
		end while (!s_axi_bvalid && n < 100);
		s_axi_bready <= 0;
		rsp = s_axi_bresp;
		tmo(n >= 100);
	endtask
	task rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
			n++;
		end while (!s_axi_rvalid && n < 100);
		s_axi_rready <= 0;
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		tmo(n >= 100);
	endtask
	task rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(what, exp, rdv);
	endtask
	task pulse(input logic [15:0] v);
		@(posedge aclk);
		{cmp_b_down, cmp_b_up, cmp_a_down, cmp_a_up} <= v;
		@(posedge aclk);
		{cmp_b_down, cmp_b_up, cmp_a_down, cmp_a_up} <= 16'h0000;
		#1;
	endtask
	// edges between two sampled zero pulses of generator 0
	task zgap;
		int n;
		n = 0;
		gap = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!gen_zero[0] && n < 200);
		do begin
			@(posedge aclk);
			gap++;
		end while (!gen_zero[0] && gap < 200);
		tmo(n >= 200 || gap >= 200);
	endtask
	task t_reset;
		rc("mode", 8'h00, 32'h0);
		rc("src_ext", 8'h04, 32'h1);
		rc("src_cmp", 8'h08, 32'h0);
		rd(8'h30);
		chk("unmapped resp", 32'h2, {30'h0, rsp});
		wr(8'h30, 32'h1);
		chk("unmapped write resp", 32'h2, {30'h0, rsp});
		wr(8'h04, 32'h1);
		chk("mapped write resp", 32'h0, {30'h0, rsp});
		$display("test reset done");
	endtask
	task t_fault;
		repeat (8) @(posedge aclk);
		chk("fault idle pins", 32'h0, {28'h0, gen_fault});
		ext_req <= 4'h1;
		repeat (8) @(posedge aclk);
		chk("fault first pin", 32'hf, {28'h0, gen_fault});
		wr(8'h0c, 32'h1);
		repeat (8) @(posedge aclk);
		chk("fault sense high", 32'he, {28'h0, gen_fault});
		ext_req <= 4'h0;
		repeat (8) @(posedge aclk);
		chk("fault sense low", 32'h1, {28'h0, gen_fault});
		wr(8'h0c, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h04);
		wr(8'h00, 32'h1);
		cmp_req <= 8'h08;
		repeat (4) @(posedge aclk);
		chk("fault unselected", 32'h0, {28'h0, gen_fault});
		cmp_req <= 8'h04;
		repeat (4) @(posedge aclk);
		chk("fault selected", 32'h1, {28'h0, gen_fault});
		cmp_req <= 8'h00;
		$display("test fault done");
	endtask
	task t_latch;
		wr(8'h00, 32'h5);
		cmp_req <= 8'h04;
		@(posedge aclk);
		cmp_req <= 8'h00;
		repeat (4) @(posedge aclk);
		rc("latched status", 8'h18, 32'h04);
		wr(8'h18, 32'h04);
		rc("status cleared", 8'h18, 32'h0);
		wr(8'h10, 32'd20);
		wr(8'h00, 32'h3);
		cmp_req <= 8'h04;
		@(posedge aclk);
		cmp_req <= 8'h00;
		repeat (10) @(posedge aclk);
		chk("min hold on", 32'h1, {28'h0, gen_fault});
		repeat (40) @(posedge aclk);
		chk("min hold off", 32'h0, {28'h0, gen_fault});
		$display("test latch done");
	endtask
	task t_irq;
		wr(8'h1c, 32'h0804);
		pulse(16'h0001);
		chk("trig masked", 32'h0, {8'h0, gen_trig});
		@(posedge aclk);
		#1;
		chk("irq on", 32'h1, {31'h0, irq});
		pulse(16'h0010);
		chk("trig on", 32'h8, {8'h0, gen_trig});
		pulse(16'h1100);
		rc("raw", 8'h20, 32'h3c);
		rc("masked", 8'h24, 32'h04);
		wr(8'h20, 32'h0);
		rc("raw kept", 8'h20, 32'h3c);
		wr(8'h20, 32'h04);
		rc("raw cleared", 8'h20, 32'h38);
		chk("irq off", 32'h0, {31'h0, irq});
		$display("test irq done");
	endtask
	task t_period;
		wr(8'h28, 32'd20);
		zgap;
		chk("period", 32'd20, gap);
		wr(8'h28, 32'd9);
		wr(8'h28, 32'd7);
		rc("programmed", 8'h28, 32'd7);
		rc("active pending", 8'h2c, 32'h10014);
		zgap;
		zgap;
		chk("new period", 32'd7, gap);
		$display("test period done");
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_fault;
		t_latch;
		t_irq;
		t_period;
		finish_test;
	end
endmodule
